// *** verilog/restart_ctrl_pkg.sv ***
/*
 Constants, types and register map of the safety output and restart
 control block. Assumes one 50 MHz clock and inputs that are already
 synchronous to it.
*/
// Operation
// - two universal I/O points, default inactive
// - an input point serves exactly one function
// - an output point ORs its selected sources
// - interlock mode needs a reset input configured
// - standby holds outputs off and laser off; ignored in lock-out and feedback fault, laser stays on there
// - remote sends field status, 1 free, 0 infringed
// - non-evaluated field always reports 1
// - occupied field always switches outputs off
// - feedback checked after interruption, before restart
// - feedback fault without interlock locks out fully
// - feedback fault with interlock: off, LED, code
// - three restart modes selectable
// - no interlock: restart at once when clear
// - delay mode: 2 to 60 s clear first
// - interlock mode: stay off until reset
// - reset with clear field switches outputs on
// - reset required shown until reset arrives; here shown only while the field is clear
package restart_ctrl_pkg;

    localparam int CLK_NS      = 20;
    localparam int SEC_NS      = 1_000_000_000;
    localparam int SEC_CYCLES  = SEC_NS / CLK_NS;
    localparam int PRE_W       = 26;
    localparam int DELAY_MIN_S = 2;
    localparam int DELAY_MAX_S = 60;
    localparam logic [5:0] DELAY_RST = 6'h02;

    localparam int NIO    = 2;
    localparam int NSRC   = 5;
    localparam int NFIELD = 4;
    localparam int NEV    = 4;
    localparam logic [NFIELD-1:0] EVAL_RST = 4'hF;

    localparam logic [7:0] A_CFG    = 8'h00;
    localparam logic [7:0] A_SRC    = 8'h04;
    localparam logic [7:0] A_DELAY  = 8'h08;
    localparam logic [7:0] A_STAT   = 8'h0C;
    localparam logic [7:0] A_EVAL   = 8'h10;
    localparam logic [7:0] A_IRQ_ST = 8'h14;
    localparam logic [7:0] A_IRQ_CL = 8'h18;
    localparam logic [7:0] A_IRQ_EN = 8'h1C;

    localparam int CFG_W   = 12;
    localparam int SRC_POS = 8;

    localparam logic [1:0] IO_INACTIVE = 2'h0;
    localparam logic [1:0] IO_INPUT    = 2'h1;
    localparam logic [1:0] IO_OUTPUT   = 2'h2;
    localparam logic [1:0] FN_STANDBY  = 2'h0;
    localparam logic [1:0] FN_FEEDBACK = 2'h1;
    localparam logic [1:0] FN_RESET    = 2'h2;
    localparam logic [1:0] RM_NONE     = 2'h0;
    localparam logic [1:0] RM_DELAY    = 2'h1;
    localparam logic [1:0] RM_INTERLK  = 2'h2;

    localparam int SRC_DEV_ERR   = 0;
    localparam int SRC_CONT_ERR  = 1;
    localparam int SRC_CONT_WARN = 2;
    localparam int SRC_WARN2     = 3;
    localparam int SRC_RST_REQ   = 4;

    localparam int EV_INFRINGE = 0;
    localparam int EV_RST_REQ  = 1;
    localparam int EV_FEEDBACK = 2;
    localparam int EV_CFG_REJ  = 3;

    // display codes, values arbitrary
    localparam logic [7:0] ERR_NONE     = 8'h00;
    localparam logic [7:0] ERR_FB_LOCK  = 8'hE1;
    localparam logic [7:0] ERR_FB_FAULT = 8'hE2;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_DELAY,
        ST_WAIT_RESET,
        ST_ON,
        ST_STANDBY,
        ST_LOCKOUT,
        ST_FB_FAULT
    } mode_e;

    // layout of the configuration register, msb first
    typedef struct packed {
        logic                  remote;
        logic                  fb_en;
        logic [1:0]            rmode;
        logic [NIO-1:0][1:0]   io_fn;
        logic [NIO-1:0][1:0]   io_mode;
    } cfg_s;

    typedef struct packed {
        mode_e                      st;
        cfg_s                       cfg;
        logic [NIO-1:0][NSRC-1:0]   src_sel;
        logic [5:0]                 dly_s;
        logic [NFIELD-1:0]          eval;
        logic [NEV-1:0]             irq_st;
        logic [NEV-1:0]             irq_en;
        logic [PRE_W-1:0]           pre;
        logic [5:0]                 sec;
        logic                       rst_prev;
        logic                       safety_switching_output;
        logic                       laser;
        logic                       led;
        logic                       rst_req;
        logic                       irq;
        logic [7:0]                 err;
        logic [NIO-1:0]             io_out;
        logic [NIO-1:0]             io_oe_n;
        logic [NFIELD-1:0]          link;
        logic [31:0]                rdata;
    } state_s;

endpackage

// *** verilog/safety_output_restart_control.sv ***
/*
 Safety switching output control: universal I/O points, standby,
 contactor feedback check with lock-out, three restart modes, field
 status for the serial safety link, register port and interrupt.
 Assumes all inputs synchronous to CLK, field evaluation done outside,
 and the pin wire resolved outside from IO_OUT and IO_OE_N.
*/
`timescale 1ns/100ps
module safety_output_restart_control
#(
    parameter int SEC_CYCLES = restart_ctrl_pkg::SEC_CYCLES
)
(
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    input  wire logic        FIELD_CLEAR,
    input  wire logic [3:0]  FIELD_FREE,
    input  wire logic        DEVICE_ERROR,
    input  wire logic        CONTAM_ERROR,
    input  wire logic        CONTAM_WARN,
    input  wire logic        WARN_FIELD2,
    input  wire logic [1:0]  IO_IN,
    output logic      [1:0]  IO_OUT,
    output logic      [1:0]  IO_OE_N,
    output logic             SAFETY_SWITCHING_OUTPUT,
    output logic             LASER_EN,
    output logic             FEEDBACK_FAULT_LED,
    output logic      [7:0]  ERR_CODE,
    output logic             RESET_REQUIRED,
    output logic      [3:0]  LINK_FIELD_STATUS,
    output logic             IRQ
);

    typedef logic [restart_ctrl_pkg::PRE_W-1:0] pre_t;

    restart_ctrl_pkg::state_s r_reg;
    restart_ctrl_pkg::state_s r_next;

    // true when some point is an input serving function fn
    function automatic logic has_fn(
        input restart_ctrl_pkg::cfg_s c,
        input logic [1:0]             fn
    );
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < restart_ctrl_pkg::NIO; i++)
        begin
            if (c.io_mode[i] == restart_ctrl_pkg::IO_INPUT &&
                c.io_fn[i] == fn)
            begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    always_comb
    begin
        logic                 standby_req;
        logic                 fb_released;
        logic                 rst_lvl;
        logic                 rst_press;
        logic                 fb_on;
        logic                 fb_ok;
        logic                 tick;
        logic                 go_on;
        logic [5:0]           sec_inc;
        logic [4:0]           srcs;
        logic [3:0]           ev;
        restart_ctrl_pkg::cfg_s cand;

        standby_req = 1'b0;
        fb_released = 1'b0;
        rst_lvl     = 1'b0;
        go_on       = 1'b0;
        rst_press   = 1'b0;
        fb_on       = 1'b0;
        fb_ok       = 1'b0;
        tick        = 1'b0;
        sec_inc     = 6'h00;
        srcs        = 5'h00;
        ev          = '0;
        cand        = restart_ctrl_pkg::cfg_s'(
                          WDATA[restart_ctrl_pkg::CFG_W-1:0]);
        r_next      = r_reg;

        // an input point feeds only its one configured function
        for (int i = 0; i < restart_ctrl_pkg::NIO; i++)
        begin
            if (r_reg.cfg.io_mode[i] == restart_ctrl_pkg::IO_INPUT)
            begin
                case (r_reg.cfg.io_fn[i])
                    restart_ctrl_pkg::FN_STANDBY:
                        standby_req = standby_req | IO_IN[i];
                    restart_ctrl_pkg::FN_FEEDBACK:
                        fb_released = fb_released | IO_IN[i];
                    restart_ctrl_pkg::FN_RESET:
                        rst_lvl = rst_lvl | IO_IN[i];
                    default:
                        rst_lvl = rst_lvl;
                endcase
            end
        end

        // operating the switch is the rising edge, not the level
        rst_press      = rst_lvl & ~r_reg.rst_prev;
        r_next.rst_prev = rst_lvl;

        // no feedback input means there is nothing to check
        fb_on = r_reg.cfg.fb_en &
                has_fn(r_reg.cfg, restart_ctrl_pkg::FN_FEEDBACK);
        fb_ok = ~fb_on | fb_released;

        tick = (r_reg.pre == pre_t'(SEC_CYCLES - 1));
        if (tick)
        begin
            r_next.pre = '0;
        end
        else
        begin
            r_next.pre = r_reg.pre + pre_t'(1);
        end
        sec_inc = r_reg.sec + 6'h01;

        case (r_reg.st)
            restart_ctrl_pkg::ST_STANDBY:
            begin
                if (!standby_req)
                begin
                    r_next.st = restart_ctrl_pkg::ST_OFF;
                end
            end
            restart_ctrl_pkg::ST_OFF:
            begin
                if (FIELD_CLEAR)
                begin
                    case (r_reg.cfg.rmode)
                        restart_ctrl_pkg::RM_NONE:
                            go_on = 1'b1;
                        restart_ctrl_pkg::RM_DELAY:
                        begin
                            r_next.st  = restart_ctrl_pkg::ST_DELAY;
                            r_next.pre = '0;
                            r_next.sec = '0;
                        end
                        restart_ctrl_pkg::RM_INTERLK:
                        begin
                            r_next.st = restart_ctrl_pkg::ST_WAIT_RESET;
                            ev[restart_ctrl_pkg::EV_RST_REQ] = 1'b1;
                        end
                        default:
                            r_next.st = restart_ctrl_pkg::ST_OFF;
                    endcase
                end
            end
            restart_ctrl_pkg::ST_DELAY:
            begin
                // any occupation restarts the whole delay
                if (!FIELD_CLEAR)
                begin
                    r_next.st = restart_ctrl_pkg::ST_OFF;
                end
                else if (tick)
                begin
                    r_next.sec = sec_inc;
                    if (sec_inc >= r_reg.dly_s)
                    begin
                        go_on = 1'b1;
                    end
                end
            end
            restart_ctrl_pkg::ST_WAIT_RESET:
            begin
                if (!FIELD_CLEAR)
                begin
                    r_next.st = restart_ctrl_pkg::ST_OFF;
                end
                else if (rst_press)
                begin
                    go_on = 1'b1;
                end
            end
            restart_ctrl_pkg::ST_ON:
            begin
                if (!FIELD_CLEAR)
                begin
                    r_next.st = restart_ctrl_pkg::ST_OFF;
                    ev[restart_ctrl_pkg::EV_INFRINGE] = 1'b1;
                end
            end
            restart_ctrl_pkg::ST_FB_FAULT:
            begin
                // retry only with clear field and released contactors
                if (rst_press && FIELD_CLEAR && fb_ok)
                begin
                    r_next.st = restart_ctrl_pkg::ST_ON;
                end
            end
            restart_ctrl_pkg::ST_LOCKOUT:
            begin
                // left only by a system reset
                r_next.st = restart_ctrl_pkg::ST_LOCKOUT;
            end
            default:
                r_next.st = restart_ctrl_pkg::ST_OFF;
        endcase

        // contactors must be released before every restart
        if (go_on)
        begin
            if (fb_ok)
            begin
                r_next.st = restart_ctrl_pkg::ST_ON;
            end
            else
            begin
                ev[restart_ctrl_pkg::EV_FEEDBACK] = 1'b1;
                if (r_reg.cfg.rmode == restart_ctrl_pkg::RM_INTERLK)
                begin
                    r_next.st = restart_ctrl_pkg::ST_FB_FAULT;
                end
                else
                begin
                    r_next.st = restart_ctrl_pkg::ST_LOCKOUT;
                end
            end
        end

        if (standby_req &&
            r_next.st != restart_ctrl_pkg::ST_LOCKOUT &&
            r_next.st != restart_ctrl_pkg::ST_FB_FAULT)
        begin
            r_next.st = restart_ctrl_pkg::ST_STANDBY;
        end

        // register writes
        if (WR)
        begin
            case (ADDR)
                restart_ctrl_pkg::A_CFG:
                begin
                    // whole write refused on an illegal combination
                    if (cand.rmode == restart_ctrl_pkg::RM_NONE ||
                        cand.rmode == restart_ctrl_pkg::RM_DELAY ||
                        (cand.rmode == restart_ctrl_pkg::RM_INTERLK &&
                         has_fn(cand, restart_ctrl_pkg::FN_RESET)))
                    begin
                        r_next.cfg = cand;
                    end
                    else
                    begin
                        ev[restart_ctrl_pkg::EV_CFG_REJ] = 1'b1;
                    end
                end
                restart_ctrl_pkg::A_SRC:
                begin
                    r_next.src_sel[0] = WDATA[4:0];
                    r_next.src_sel[1] = WDATA[12:8];
                end
                restart_ctrl_pkg::A_DELAY:
                begin
                    if (WDATA < 32'(restart_ctrl_pkg::DELAY_MIN_S))
                    begin
                        r_next.dly_s = 6'(restart_ctrl_pkg::DELAY_MIN_S);
                    end
                    else if (WDATA > 32'(restart_ctrl_pkg::DELAY_MAX_S))
                    begin
                        r_next.dly_s = 6'(restart_ctrl_pkg::DELAY_MAX_S);
                    end
                    else
                    begin
                        r_next.dly_s = WDATA[5:0];
                    end
                end
                restart_ctrl_pkg::A_EVAL:
                    r_next.eval = WDATA[3:0];
                restart_ctrl_pkg::A_IRQ_CL:
                    r_next.irq_st = r_reg.irq_st & ~WDATA[3:0];
                restart_ctrl_pkg::A_IRQ_EN:
                    r_next.irq_en = WDATA[3:0];
                default:
                    r_next.irq_en = r_reg.irq_en;
            endcase
        end

        // a new event wins over a clear in the same cycle
        r_next.irq_st = r_next.irq_st | ev;
        r_next.irq    = |(r_next.irq_st & r_next.irq_en);

        r_next.safety_switching_output    = (r_next.st == restart_ctrl_pkg::ST_ON);
        r_next.laser   = (r_next.st != restart_ctrl_pkg::ST_STANDBY);
        r_next.led     = (r_next.st == restart_ctrl_pkg::ST_FB_FAULT);
        r_next.rst_req = (r_next.st ==
                          restart_ctrl_pkg::ST_WAIT_RESET);
        case (r_next.st)
            restart_ctrl_pkg::ST_LOCKOUT:
                r_next.err = restart_ctrl_pkg::ERR_FB_LOCK;
            restart_ctrl_pkg::ST_FB_FAULT:
                r_next.err = restart_ctrl_pkg::ERR_FB_FAULT;
            default:
                r_next.err = restart_ctrl_pkg::ERR_NONE;
        endcase

        srcs = '0;
        srcs[restart_ctrl_pkg::SRC_DEV_ERR]   = DEVICE_ERROR;
        srcs[restart_ctrl_pkg::SRC_CONT_ERR]  = CONTAM_ERROR;
        srcs[restart_ctrl_pkg::SRC_CONT_WARN] = CONTAM_WARN;
        srcs[restart_ctrl_pkg::SRC_WARN2]     = WARN_FIELD2;
        srcs[restart_ctrl_pkg::SRC_RST_REQ]   = r_reg.rst_req;
        for (int i = 0; i < restart_ctrl_pkg::NIO; i++)
        begin
            if (r_reg.cfg.io_mode[i] == restart_ctrl_pkg::IO_OUTPUT)
            begin
                r_next.io_out[i]  = |(r_reg.src_sel[i] & srcs);
                r_next.io_oe_n[i] = 1'b0;
            end
            else
            begin
                r_next.io_out[i]  = 1'b0;
                r_next.io_oe_n[i] = 1'b1;
            end
        end

        // standard variant keeps the link idle at all ones
        if (r_reg.cfg.remote)
        begin
            r_next.link = ~r_reg.eval | FIELD_FREE;
        end
        else
        begin
            r_next.link = '1;
        end

        r_next.rdata = '0;
        if (RD)
        begin
            case (ADDR)
                restart_ctrl_pkg::A_CFG:
                    r_next.rdata = 32'(r_reg.cfg);
                restart_ctrl_pkg::A_SRC:
                    r_next.rdata = {19'h0, r_reg.src_sel[1],
                                    3'h0, r_reg.src_sel[0]};
                restart_ctrl_pkg::A_DELAY:
                    r_next.rdata = {26'h0, r_reg.dly_s};
                restart_ctrl_pkg::A_STAT:
                    r_next.rdata = {25'h0, r_reg.st, r_reg.rst_req,
                                    r_reg.led, r_reg.laser, r_reg.safety_switching_output};
                restart_ctrl_pkg::A_EVAL:
                    r_next.rdata = {28'h0, r_reg.eval};
                restart_ctrl_pkg::A_IRQ_ST:
                    r_next.rdata = {28'h0, r_reg.irq_st};
                restart_ctrl_pkg::A_IRQ_EN:
                    r_next.rdata = {28'h0, r_reg.irq_en};
                default:
                    r_next.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            r_reg         <= '0;
            r_reg.dly_s   <= restart_ctrl_pkg::DELAY_RST;
            r_reg.eval    <= restart_ctrl_pkg::EVAL_RST;
            r_reg.laser   <= 1'b1;
            r_reg.io_oe_n <= 2'h3;
            r_reg.link    <= 4'hF;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign RDATA                   = r_reg.rdata;
    assign IO_OUT                  = r_reg.io_out;
    assign IO_OE_N                 = r_reg.io_oe_n;
    assign SAFETY_SWITCHING_OUTPUT = r_reg.safety_switching_output;
    assign LASER_EN                = r_reg.laser;
    assign FEEDBACK_FAULT_LED      = r_reg.led;
    assign ERR_CODE                = r_reg.err;
    assign RESET_REQUIRED          = r_reg.rst_req;
    assign LINK_FIELD_STATUS       = r_reg.link;
    assign IRQ                     = r_reg.irq;

endmodule

// *** test/restart_props.sv ***
/*
 Checker of the safety output block, on the top module ports only.
 Assumes io0 as reset input and io1 as feedback input in interlock use.
*/
`timescale 1ns/100ps
module restart_props
(
    input wire logic        CLK,
    input wire logic        SYS_RST,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    input wire logic        FIELD_CLEAR,
    input wire logic [1:0]  IO_IN,
    input wire logic [1:0]  IO_OE_N,
    input wire logic        SAFETY_SWITCHING_OUTPUT,
    input wire logic        LASER_EN,
    input wire logic        FEEDBACK_FAULT_LED,
    input wire logic [7:0]  ERR_CODE,
    input wire logic        RESET_REQUIRED
);
    logic on;
    assign on = SAFETY_SWITCHING_OUTPUT;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (SYS_RST);

    AST_FIELD_OFF: assert property (!FIELD_CLEAR |=> !on)
        else $error("output on with field occupied");
    AST_STANDBY: assert property (!LASER_EN |-> !on)
        else $error("output on in standby");
    AST_ON_CAUSE: assert property (
        $rose(on) |-> $past(FIELD_CLEAR))
        else $error("output on without clear field");
    AST_REQ_OFF: assert property (
        RESET_REQUIRED && !$rose(IO_IN[0]) |=> !on)
        else $error("output on while reset required");
    AST_LED_FAULT: assert property (
        FEEDBACK_FAULT_LED |-> !on
        && ERR_CODE == restart_ctrl_pkg::ERR_FB_FAULT)
        else $error("feedback fault indication wrong");
    AST_LOCK_HOLD: assert property (
        ERR_CODE == restart_ctrl_pkg::ERR_FB_LOCK |=> $stable(ERR_CODE) && !on)
        else $error("lock-out left without reset");
    AST_RESET_PRESS: assert property (
        RESET_REQUIRED && !FEEDBACK_FAULT_LED && FIELD_CLEAR && IO_IN[1]
        && IO_OE_N[0] && $rose(IO_IN[0]) |=> on)
        else $error("reset press with clear field ignored");
    AST_READ_IDLE: assert property (!RD |=> RDATA == 32'h0)
        else $error("read data outside read slot");

    cover property ($rose(on));
    cover property ($rose(RESET_REQUIRED));
    cover property ($rose(FEEDBACK_FAULT_LED));
    cover property (ERR_CODE == restart_ctrl_pkg::ERR_FB_LOCK);
endmodule

// *** test/far_side_model.sv ***
/*
 Far side: contactors with release feedback, operator reset switch
 and a machine control with its own start switch.
 Assumes the bench resolves pin levels from these outputs.
*/
`timescale 1ns/100ps
module far_side_model
(
    input  wire logic clk,
    input  wire logic out_on,
    input  wire logic weld,
    input  wire logic press,
    input  wire logic start,
    output logic      fb_released,
    output logic      reset_sw,
    output logic      machine_run
);
    logic [1:0] hold = 2'h0;
    logic       armed = 1'b0;

    // a welded contact never reports release
    assign fb_released = !out_on && !weld;
    assign reset_sw = hold != 2'h0;

    always_ff @(posedge clk)
    begin
        hold <= press ? 2'h3 : (reset_sw ? hold - 2'h1 : 2'h0);
        armed <= out_on && (armed || reset_sw);
        machine_run <= out_on && (machine_run || (start && armed));
    end
endmodule

// *** test/safety_output_restart_control_bench.sv ***
/*
 Self-checking bench of the safety output block with far side model.
 Assumes a 50 MHz clock and a one-second count shortened to SEC.
*/
`timescale 1ns/100ps
module safety_output_restart_control_bench;
    localparam int SEC = 10;
    logic        CLK = 1'b0;
    logic        SYS_RST = 1'b1;
    logic [7:0]  ADDR = 8'h00;
    logic [31:0] WDATA = 32'h0;
    logic        WR = 1'b0;
    logic        RD = 1'b0;
    logic        FIELD_CLEAR = 1'b0;
    logic [3:0]  FIELD_FREE = 4'hF;
    logic [3:0]  src = 4'h0;
    logic        sb = 1'b0;
    logic        weld = 1'b0;
    logic        press = 1'b0;
    logic        start = 1'b0;
    logic [31:0] RDATA;
    logic [1:0]  IO_IN;
    logic [1:0]  IO_OUT;
    logic [1:0]  IO_OE_N;
    logic        sso;
    logic        laser;
    logic        led;
    logic        rreq;
    logic        IRQ;
    logic [7:0]  err;
    logic [3:0]  link;
    logic        fb;
    logic        rsw;
    logic        run;
    int          failures = 0;
    int          n_compared = 0;

    always #10 CLK = ~CLK;
    assign IO_IN[0] = IO_OE_N[0] ? (rsw | sb) : IO_OUT[0];
    assign IO_IN[1] = IO_OE_N[1] ? fb : IO_OUT[1];

    safety_output_restart_control #(.SEC_CYCLES(SEC)) u_dut
    (
        .CLK(CLK), .SYS_RST(SYS_RST), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .FIELD_CLEAR(FIELD_CLEAR),
        .FIELD_FREE(FIELD_FREE), .DEVICE_ERROR(src[0]),
        .CONTAM_ERROR(src[1]), .CONTAM_WARN(src[2]), .WARN_FIELD2(src[3]),
        .IO_IN(IO_IN), .IO_OUT(IO_OUT), .IO_OE_N(IO_OE_N),
        .SAFETY_SWITCHING_OUTPUT(sso), .LASER_EN(laser),
        .FEEDBACK_FAULT_LED(led), .ERR_CODE(err), .RESET_REQUIRED(rreq),
        .LINK_FIELD_STATUS(link), .IRQ(IRQ)
    );

    far_side_model u_far
    (
        .clk(CLK), .out_on(sso), .weld(weld), .press(press),
        .start(start), .fb_released(fb), .reset_sw(rsw),
        .machine_run(run)
    );

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] ex);
        n_compared++;
        if (seen !== ex)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, ex, seen);
        end
    endtask

    task automatic hop(input int n);
        repeat (n) @(negedge CLK);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] ex);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        chk("rdata", RDATA, ex);
    endtask

    task automatic field(input logic v);
        @(posedge CLK);
        FIELD_CLEAR <= v;
    endtask

    task automatic push();
        @(posedge CLK);
        press <= 1'b1;
        @(posedge CLK);
        press <= 1'b0;
    endtask

    // bounded wait; running out ends the run
    task automatic wait_on(input logic e, input int lim);
        int k;
        k = 0;
        while (sso !== e && k < lim)
        begin
            @(negedge CLK);
            k++;
        end
        chk("out", 32'(sso), 32'(e));
        if (sso !== e)
            summarize();
    endtask

    initial
    begin
        void'($urandom(67438));
        repeat (5) @(posedge CLK);
        SYS_RST <= 1'b0;
        hop(1);
        rdc(8'h0C, 32'h2);
        rdc(8'h00, 32'h0);
        rdc(8'h08, 32'h2);
        rdc(8'h10, 32'hF);
        rdc(8'h20, 32'h0);
        chk("oe", 32'(IO_OE_N), 32'h3);
        wr(8'h1C, 32'hF);
        field(1'b1);
        wait_on(1'b1, 3);
        field(1'b0);
        hop(2);
        chk("off", 32'(sso), 32'h0);
        chk("irq", 32'(IRQ), 32'h1);
        rdc(8'h14, 32'h1);
        wr(8'h18, 32'h1);
        hop(2);
        chk("irq", 32'(IRQ), 32'h0);
        field(1'b1);
        hop(2);
        chk("on", 32'(sso), 32'h1);
        wr(8'h00, 32'h800);
        wr(8'h10, 32'h5);
        repeat (4)
        begin
            @(posedge CLK);
            FIELD_FREE <= 4'($urandom);
            hop(2);
            chk("link", 32'(link), 32'(4'hA | FIELD_FREE));
        end
        wr(8'h00, 32'h2);
        wr(8'h04, 32'h15);
        repeat (6)
        begin
            @(posedge CLK);
            src <= 4'($urandom);
            hop(3);
            chk("pin", 32'(IO_OUT[0]), 32'(|(src & 4'h5)));
        end
        chk("oe", 32'(IO_OE_N), 32'h2);
        wr(8'h00, 32'h1);
        @(posedge CLK);
        sb <= 1'b1;
        hop(2);
        chk("laser", 32'(laser), 32'h0);
        chk("sb", 32'(sso), 32'h0);
        @(posedge CLK);
        sb <= 1'b0;
        wait_on(1'b1, 6);
        wr(8'h00, 32'h100);
        wr(8'h08, 32'h1);
        rdc(8'h08, 32'h2);
        wr(8'h08, 32'h3D);
        rdc(8'h08, 32'h3C);
        wr(8'h08, 32'h2);
        field(1'b0);
        field(1'b1);
        hop(2 * SEC);
        chk("delay", 32'(sso), 32'h0);
        wait_on(1'b1, 6);
        wr(8'h18, 32'hF);
        wr(8'h00, 32'h200);
        rdc(8'h00, 32'h100);
        rdc(8'h14, 32'h8);
        wr(8'h00, 32'h221);
        push();
        wait_on(1'b1, 6);
        @(posedge CLK);
        start <= 1'b1;
        @(posedge CLK);
        start <= 1'b0;
        hop(2);
        chk("machine", 32'(run), 32'h1);
        field(1'b0);
        field(1'b1);
        hop(4);
        chk("req", 32'(rreq), 32'h1);
        chk("held", 32'(sso), 32'h0);
        field(1'b0);
        push();
        hop(6);
        field(1'b1);
        hop(4);
        chk("ignored", 32'(sso), 32'h0);
        push();
        wait_on(1'b1, 6);
        chk("req", 32'(rreq), 32'h0);
        wr(8'h00, 32'h665);
        weld <= 1'b1;
        field(1'b0);
        field(1'b1);
        hop(2);
        push();
        hop(6);
        chk("led", 32'(led), 32'h1);
        chk("code", 32'(err), 32'(restart_ctrl_pkg::ERR_FB_FAULT));
        chk("fault", 32'(sso), 32'h0);
        @(posedge CLK);
        weld <= 1'b0;
        push();
        wait_on(1'b1, 8);
        chk("led", 32'(led), 32'h0);
        wr(8'h00, 32'h444);
        weld <= 1'b1;
        field(1'b0);
        field(1'b1);
        hop(SEC);
        chk("code", 32'(err), 32'(restart_ctrl_pkg::ERR_FB_LOCK));
        chk("lock", 32'(sso), 32'h0);
        @(posedge CLK);
        SYS_RST <= 1'b1;
        weld <= 1'b0;
        repeat (2) @(posedge CLK);
        SYS_RST <= 1'b0;
        hop(2);
        chk("code", 32'(err), 32'h0);
        wait_on(1'b1, 4);
        summarize();
    end
endmodule

bind safety_output_restart_control restart_props u_props
(
    .CLK(CLK), .SYS_RST(SYS_RST), .RD(RD), .RDATA(RDATA),
    .FIELD_CLEAR(FIELD_CLEAR), .IO_IN(IO_IN), .IO_OE_N(IO_OE_N),
    .SAFETY_SWITCHING_OUTPUT(SAFETY_SWITCHING_OUTPUT),
    .LASER_EN(LASER_EN), .FEEDBACK_FAULT_LED(FEEDBACK_FAULT_LED),
    .ERR_CODE(ERR_CODE), .RESET_REQUIRED(RESET_REQUIRED)
);
